/* File: design/tgn_top.sv */
// Function
// - two tone generators, each giving a continuous 1kHz sinusoid
// - control bit 0 enables generator A, bit 1 enables generator B
// - bits 9:8 advance B's phase over A by 0/90/180/270 degrees
// - bit 4 / bit 5 swap the tone for a constant DC level
// - DC level is 24-bit two's complement, 4 integer, 20 fraction bits
// - 100000h means plus one, f00000h means minus one, full scale
// - level split: upper 16 bits reset 1000h, lower 8 bits reset 00h
// - both generators step on one shared sample-rate tick
// - each generator reachable by its own mixer source-select code
`timescale 1ns/1ps
`default_nettype none
`include "tgn_params.svh"
module tgn_top #(
  parameter int FS_HZ = `TGN_FS_HZ,
  parameter int FIFO_DEPTH = `TGN_FIFO_DEPTH
) (
  input wire logic i_ref_clk,                         // 25 MHz clock
  input wire logic i_rst_n,                           // sync reset, low
  input wire logic i_clk_en,                          // freezes all state
  input wire tgn_pkg::tgn_addr_t i_reg_addr,          // register index
  input wire tgn_pkg::tgn_word_t i_reg_wdata,         // write data
  input wire logic i_reg_wr,                          // write strobe
  input wire logic i_reg_rd,                          // read strobe
  output tgn_pkg::tgn_word_t o_reg_rdata,             // read data
  output logic o_reg_rvalid,                          // read data valid
  input wire logic i_sample_tick,                     // shared rate tick
  input wire logic [7:0] i_mixer_source_select,       // consumer's code
  input wire logic i_out_ready,                       // consumer ready
  output logic o_out_valid,                           // sample pair valid
  output tgn_pkg::tgn_sample_t o_tone_a,              // generator A
  output tgn_pkg::tgn_sample_t o_tone_b,              // generator B
  output tgn_pkg::tgn_sample_t o_sel_sample,          // selected source
  output logic o_sel_hit,                             // code matched
  output logic [$clog2(FIFO_DEPTH+1)-1:0] o_fifo_level // fifo fill
);
  import tgn_pkg::*;

  localparam logic [31:0] PHASE_INC =
    32'(((64'd1 << 32) * 64'(`TGN_TONE_HZ)) / 64'(FS_HZ));
  localparam int CW = $clog2(FIFO_DEPTH+1);

  // register file
  tgn_word_t ctrl_reg, ctrl_next;
  tgn_word_t a_hi_reg, a_hi_next, b_hi_reg, b_hi_next;
  logic [7:0] a_lo_reg, a_lo_next, b_lo_reg, b_lo_next;
  tgn_word_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // generator state
  tgn_phase_t acc_reg, acc_next;
  logic pend_reg, pend_next;
  logic pend_eff, push, fifo_wr_ready;
  tgn_phase_t phase_a, phase_b;
  tgn_sample_t sine_a, sine_b, samp_a, samp_b, lvl_a, lvl_b;
  logic en_a, en_b, ovd_a, ovd_b;
  tgn_offset_t offset;

  // output stage
  logic fifo_rd_valid, load;
  logic [47:0] fifo_rd_data;
  logic ovalid_reg, ovalid_next, hit_reg, hit_next;
  tgn_sample_t oa_reg, oa_next, ob_reg, ob_next, sel_reg, sel_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    a_hi_next = a_hi_reg;
    a_lo_next = a_lo_reg;
    b_hi_next = b_hi_reg;
    b_lo_next = b_lo_reg;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `TGN_REG_CTRL: begin
          ctrl_next = '0;
          ctrl_next[`TGN_BIT_A_EN] = i_reg_wdata[`TGN_BIT_A_EN];
          ctrl_next[`TGN_BIT_B_EN] = i_reg_wdata[`TGN_BIT_B_EN];
          ctrl_next[`TGN_BIT_A_OVD] = i_reg_wdata[`TGN_BIT_A_OVD];
          ctrl_next[`TGN_BIT_B_OVD] = i_reg_wdata[`TGN_BIT_B_OVD];
          ctrl_next[`TGN_BIT_OFS_HI:`TGN_BIT_OFS_LO] =
            i_reg_wdata[`TGN_BIT_OFS_HI:`TGN_BIT_OFS_LO];
        end
        `TGN_REG_A_LVL_HI: a_hi_next = i_reg_wdata;
        `TGN_REG_A_LVL_LO: a_lo_next = i_reg_wdata[7:0];
        `TGN_REG_B_LVL_HI: b_hi_next = i_reg_wdata;
        `TGN_REG_B_LVL_LO: b_lo_next = i_reg_wdata[7:0];
        default: ;
      endcase
    end
    rvalid_next = i_reg_rd;
    rdata_next = '0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `TGN_REG_CTRL: rdata_next = ctrl_reg;
        `TGN_REG_A_LVL_HI: rdata_next = a_hi_reg;
        `TGN_REG_A_LVL_LO: rdata_next = {8'h00, a_lo_reg};
        `TGN_REG_B_LVL_HI: rdata_next = b_hi_reg;
        `TGN_REG_B_LVL_LO: rdata_next = {8'h00, b_lo_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= `TGN_RST_CTRL;
      a_hi_reg <= `TGN_RST_LVL_HI;
      a_lo_reg <= `TGN_RST_LVL_LO;
      b_hi_reg <= `TGN_RST_LVL_HI;
      b_lo_reg <= `TGN_RST_LVL_LO;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else if (i_clk_en) begin
      ctrl_reg <= ctrl_next;
      a_hi_reg <= a_hi_next;
      a_lo_reg <= a_lo_next;
      b_hi_reg <= b_hi_next;
      b_lo_reg <= b_lo_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign en_a = ctrl_reg[`TGN_BIT_A_EN];
  assign en_b = ctrl_reg[`TGN_BIT_B_EN];
  assign ovd_a = ctrl_reg[`TGN_BIT_A_OVD];
  assign ovd_b = ctrl_reg[`TGN_BIT_B_OVD];
  assign offset = tgn_offset_t'(ctrl_reg[`TGN_BIT_OFS_HI:`TGN_BIT_OFS_LO]);
  assign lvl_a = {a_hi_reg, a_lo_reg};
  assign lvl_b = {b_hi_reg, b_lo_reg};

  // one accumulator drives both, so the offset cannot drift
  assign phase_a = acc_reg;
  assign phase_b = acc_reg + {offset, 30'h0};

  tgn_sine u_sine_a (
    .i_phase(phase_a[31:26]),
    .o_sample(sine_a)
  );

  tgn_sine u_sine_b (
    .i_phase(phase_b[31:26]),
    .o_sample(sine_b)
  );

  always_comb begin
    // a tick waits while the fifo is full
    pend_eff = pend_reg || i_sample_tick;
    push = pend_eff && fifo_wr_ready;
    pend_next = pend_eff && !push;
    samp_a = !en_a ? '0 : (ovd_a ? lvl_a : sine_a);
    samp_b = !en_b ? '0 : (ovd_b ? lvl_b : sine_b);
    if (!en_a && !en_b) begin
      acc_next = '0;
    end else if (push) begin
      acc_next = acc_reg + PHASE_INC;
    end else begin
      acc_next = acc_reg;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      acc_reg <= '0;
      pend_reg <= 1'b0;
    end else if (i_clk_en) begin
      acc_reg <= acc_next;
      pend_reg <= pend_next;
    end
  end

  tgn_fifo #(
    .WIDTH(48),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_wr_valid(push),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data({samp_a, samp_b}),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(load),
    .o_rd_data(fifo_rd_data),
    .o_count(o_fifo_level)
  );

  always_comb begin
    load = !ovalid_reg || i_out_ready;
    ovalid_next = load ? fifo_rd_valid : ovalid_reg;
    oa_next = oa_reg;
    ob_next = ob_reg;
    sel_next = sel_reg;
    hit_next = hit_reg;
    if (load && fifo_rd_valid) begin
      oa_next = fifo_rd_data[47:24];
      ob_next = fifo_rd_data[23:0];
      hit_next = 1'b1;
      unique case (i_mixer_source_select)
        `TGN_SRC_TONE_A: sel_next = fifo_rd_data[47:24];
        `TGN_SRC_TONE_B: sel_next = fifo_rd_data[23:0];
        default: begin
          sel_next = '0;
          hit_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ovalid_reg <= 1'b0;
      oa_reg <= '0;
      ob_reg <= '0;
      sel_reg <= '0;
      hit_reg <= 1'b0;
    end else if (i_clk_en) begin
      ovalid_reg <= ovalid_next;
      oa_reg <= oa_next;
      ob_reg <= ob_next;
      sel_reg <= sel_next;
      hit_reg <= hit_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_out_valid = ovalid_reg;
  assign o_tone_a = oa_reg;
  assign o_tone_b = ob_reg;
  assign o_sel_sample = sel_reg;
  assign o_sel_hit = hit_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_disabled_zero:
  assert property (push && !en_a |-> samp_a == '0 && samp_b == (en_b ? samp_b : '0))
    else $error("disabled generator produced a nonzero sample");
  a_enable_bits:
  assert property (push && en_b && !ovd_b |-> samp_b == sine_b)
    else $error("enabled generator B not giving tone");
  a_override_level:
  assert property (push && en_a && ovd_a |-> samp_a == {a_hi_reg, a_lo_reg})
    else $error("override did not output the DC level");
  a_phase_offset:
  assert property (phase_b - phase_a == {ctrl_reg[9:8], 30'h0})
    else $error("phase offset between generators wrong");
  a_phase_step:
  assert property (i_clk_en && push && (en_a || en_b) |=>
                   acc_reg == $past(acc_reg) + PHASE_INC)
    else $error("phase did not advance by one tone step");
  a_tone_range:
  assert property (push && en_a && !ovd_a |->
                   samp_a <= 24'sh100000 && samp_a >= -24'sh100000)
    else $error("tone exceeds full scale");
  a_level_reset:
  assert property ($past(!i_rst_n) |-> a_hi_reg == 16'h1000 && a_lo_reg == 8'h00
                   && b_hi_reg == 16'h1000 && b_lo_reg == 8'h00)
    else $error("level registers not at reset value");
  a_shared_tick:
  assert property (push |-> pend_reg || i_sample_tick)
    else $error("sample pushed without a rate tick");
  a_source_pick:
  assert property (i_clk_en && load && fifo_rd_valid &&
                   i_mixer_source_select == 8'h04 |=> hit_reg && sel_reg == oa_reg)
    else $error("source code 04h did not pick generator A");
  a_int_format:
  assert property (push && en_b && ovd_b |-> samp_b[23:20] == b_hi_reg[15:12])
    else $error("integer part misplaced in DC level");

  c_tone_pair:
  cover property (push && en_a && en_b && !ovd_a && !ovd_b && offset == TGN_DEG_90);
  c_dc_out:
  cover property (o_out_valid && o_sel_hit && ovd_b);
  c_backpressure:
  cover property (pend_reg && !fifo_wr_ready);
endmodule
`default_nettype wire

/* File: design/tgn_params.svh */
`ifndef TGN_PARAMS_SVH
`define TGN_PARAMS_SVH

// register indices
`define TGN_REG_CTRL 8'h20
`define TGN_REG_A_LVL_HI 8'h21
`define TGN_REG_A_LVL_LO 8'h22
`define TGN_REG_B_LVL_HI 8'h23
`define TGN_REG_B_LVL_LO 8'h24

// control field positions
`define TGN_BIT_A_EN 0
`define TGN_BIT_B_EN 1
`define TGN_BIT_A_OVD 4
`define TGN_BIT_B_OVD 5
`define TGN_BIT_OFS_LO 8
`define TGN_BIT_OFS_HI 9

// reset values
`define TGN_RST_CTRL 16'h0000
`define TGN_RST_LVL_HI 16'h1000
`define TGN_RST_LVL_LO 8'h00

// source-select codes seen by the mixers
`define TGN_SRC_TONE_A 8'h04
`define TGN_SRC_TONE_B 8'h05

// tone, sample rate and fifo depth
`define TGN_TONE_HZ 1000
`define TGN_FS_HZ 48000
`define TGN_FIFO_DEPTH 8

`endif

/* File: design/tgn_pkg.sv */
package tgn_pkg;
  typedef logic signed [23:0] tgn_sample_t;
  typedef logic [31:0] tgn_phase_t;
  typedef logic [7:0] tgn_addr_t;
  typedef logic [15:0] tgn_word_t;
  typedef enum logic [1:0] {
    TGN_DEG_0 = 2'b00,
    TGN_DEG_90 = 2'b01,
    TGN_DEG_180 = 2'b10,
    TGN_DEG_270 = 2'b11
  } tgn_offset_t;
endpackage

/* File: design/tgn_sine.sv */
`timescale 1ns/1ps
`default_nettype none
module tgn_sine (
  input wire logic [5:0] i_phase,          // top phase bits
  output tgn_pkg::tgn_sample_t o_sample    // signed sine sample
);
  import tgn_pkg::*;

  // quarter wave, 17 points, +1 scaled to 20-bit fraction
  function automatic logic [19:0] qsin(input logic [4:0] k);
    case (k)
      5'd0: qsin = 20'h00000;
      5'd1: qsin = 20'h1917a;
      5'd2: qsin = 20'h31f17;
      5'd3: qsin = 20'h4a505;
      5'd4: qsin = 20'h61f7c;
      5'd5: qsin = 20'h78ade;
      5'd6: qsin = 20'h8e3a3;
      5'd7: qsin = 20'ha2680;
      5'd8: qsin = 20'hb5056;
      5'd9: qsin = 20'hc5e46;
      5'd10: qsin = 20'hd4dba;
      5'd11: qsin = 20'he1c60;
      5'd12: qsin = 20'hec83d;
      5'd13: qsin = 20'hf4fa7;
      5'd14: qsin = 20'hfb14c;
      5'd15: qsin = 20'hfec46;
      default: qsin = 20'hfffff;
    endcase
  endfunction

  logic [4:0] k;
  tgn_sample_t mag;

  always_comb begin
    // mirror index in the falling quadrants
    k = i_phase[4] ? 5'd16 - {1'b0, i_phase[3:0]} : {1'b0, i_phase[3:0]};
    mag = {4'h0, qsin(k)};
    o_sample = i_phase[5] ? -mag : mag;
  end
endmodule
`default_nettype wire

/* File: design/tgn_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tgn_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,                    // clock
  input wire logic i_rst_n,                      // sync reset, low
  input wire logic i_clk_en,                     // freezes state when low
  input wire logic i_wr_valid,                   // write request
  output logic o_wr_ready,                       // space available
  input wire logic [WIDTH-1:0] i_wr_data,        // write word
  output logic o_rd_valid,                       // word available
  input wire logic i_rd_ready,                   // consumer takes word
  output logic [WIDTH-1:0] o_rd_data,            // head word
  output logic [$clog2(DEPTH+1)-1:0] o_count     // fill level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic do_wr, do_rd;

  assign o_wr_ready = (count_reg != CW'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign o_rd_data = mem[rd_ptr_reg];
  assign o_count = count_reg;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    do_wr = i_clk_en && i_wr_valid && o_wr_ready;
    do_rd = i_clk_en && i_rd_ready && o_rd_valid;
    wr_ptr_next = do_wr ? bump(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = do_rd ? bump(rd_ptr_reg) : rd_ptr_reg;
    count_next = count_reg + CW'(do_wr) - CW'(do_rd);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_clk_en) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_fifo_full_stall:
  assert property (count_reg == CW'(DEPTH) |-> !o_wr_ready)
    else $error("fifo accepts writes while full");
  a_fifo_count_step:
  assert property (i_clk_en && do_wr && !do_rd |=> count_reg == $past(count_reg) + 1'b1)
    else $error("fifo count did not follow a lone write");
  c_fifo_fills:
  cover property (count_reg == CW'(DEPTH));
endmodule
`default_nettype wire

/* File: verif/tgn_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module tgn_sink (
  input wire logic i_ref_clk,                 // clock
  input wire logic i_rst_n,                   // sync reset, low
  input wire logic i_stall,                   // hold off taking pairs
  input wire logic i_valid,                   // pair offered
  input wire tgn_pkg::tgn_sample_t i_tone_a,  // generator A
  input wire tgn_pkg::tgn_sample_t i_tone_b,  // generator B
  input wire tgn_pkg::tgn_sample_t i_sel,     // selected source
  input wire logic i_hit,                     // code matched
  output logic o_ready,                       // consumer ready
  output tgn_pkg::tgn_sample_t o_a,           // last A taken
  output tgn_pkg::tgn_sample_t o_b,           // last B taken
  output tgn_pkg::tgn_sample_t o_s,           // last selected taken
  output logic o_h,                           // last hit taken
  output logic [15:0] o_cnt                   // pairs taken
);
  initial o_ready = 1'b0;
  // ready moves off the sampling edge, like any consumer
  always @(negedge i_ref_clk) begin
    o_ready <= i_rst_n && !i_stall;
  end
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_cnt <= 16'h0000;
    end else if (i_valid && o_ready) begin
      o_cnt <= o_cnt + 16'h0001;
      o_a <= i_tone_a;
      o_b <= i_tone_b;
      o_s <= i_sel;
      o_h <= i_hit;
    end
  end
endmodule
`default_nettype wire

/* File: verif/dual_tone_generator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_tone_generator_tb;
  import tgn_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  tgn_addr_t i_reg_addr = 8'h00;
  tgn_word_t i_reg_wdata = 16'h0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_sample_tick = 1'b0;
  logic [7:0] sel_code = 8'h04;
  logic stall = 1'b0;
  logic rdy, vld, hit, s_h;
  tgn_word_t rdata;
  logic rvalid;
  tgn_sample_t ta, tb, ts, s_a, s_b, s_s;
  logic [3:0] level;
  logic [15:0] s_cnt;
  int err_count = 0;
  int compares = 0;
  tgn_sample_t aref[50];

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  tgn_top i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_clk_en(1'b1), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_sample_tick(i_sample_tick),
    .i_mixer_source_select(sel_code), .i_out_ready(rdy),
    .o_out_valid(vld), .o_tone_a(ta), .o_tone_b(tb), .o_sel_sample(ts),
    .o_sel_hit(hit), .o_fifo_level(level));

  tgn_sink i_sink (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_stall(stall), .i_valid(vld), .i_tone_a(ta), .i_tone_b(tb),
    .i_sel(ts), .i_hit(hit), .o_ready(rdy), .o_a(s_a), .o_b(s_b),
    .o_s(s_s), .o_h(s_h), .o_cnt(s_cnt));

  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bad(input string msg);
    err_count++;
    $display("unexpected %0t %s", $time, msg);
  endtask

  task automatic chk_w(input tgn_word_t got, input tgn_word_t exp);
    compares++;
    if (got !== exp) bad($sformatf("word %h want %h", got, exp));
  endtask

  task automatic chk_s(input tgn_sample_t got, input tgn_sample_t exp);
    compares++;
    if (got !== exp) bad($sformatf("sample %h want %h", got, exp));
  endtask

  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) bad($sformatf("flag %b want %b", got, exp));
  endtask

  // all bus tasks start and end at a falling edge
  task automatic reg_wr(input tgn_addr_t a, input tgn_word_t d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_chk(input tgn_addr_t a, input tgn_word_t exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_ref_clk);
    i_reg_rd = 1'b0;
    chk_b(rvalid, 1'b1);
    chk_w(rdata, exp);
  endtask

  task automatic get_pair();
    logic [15:0] c0;
    int n;
    c0 = s_cnt;
    i_sample_tick = 1'b1;
    @(negedge i_ref_clk);
    i_sample_tick = 1'b0;
    n = 0;
    while (s_cnt == c0 && n < 20) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 20) bad("no sample pair");
  endtask

  task automatic t_reset_regs();
    tgn_word_t exp[6] = '{16'h0000, 16'h1000, 16'h0000,
                          16'h1000, 16'h0000, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      reg_chk(8'h20 + 8'(i), exp[i]);
    end
    reg_wr(8'h20, 16'hffff);
    reg_chk(8'h20, 16'h0333);
    reg_wr(8'h22, 16'hffff);
    reg_chk(8'h22, 16'h00ff);
  endtask

  task automatic t_dc_level();
    reg_wr(8'h21, 16'hf000);
    reg_wr(8'h22, 16'h0000);
    reg_wr(8'h24, 16'h0055);
    reg_wr(8'h20, 16'h0033);
    sel_code = 8'h04;
    get_pair();
    chk_s(s_a, 24'hf00000);
    chk_s(s_b, 24'h100055);
    chk_s(s_s, 24'hf00000);
    chk_b(s_h, 1'b1);
    sel_code = 8'h05;
    get_pair();
    chk_s(s_s, 24'h100055);
    sel_code = 8'h0d;
    get_pair();
    chk_b(s_h, 1'b0);
    chk_s(s_s, 24'h000000);
    reg_wr(8'h20, 16'h0031);
    get_pair();
    chk_s(s_a, 24'hf00000);
    chk_s(s_b, 24'h000000);
    reg_wr(8'h20, 16'h0030);
    get_pair();
    chk_s(s_a, 24'h000000);
  endtask

  // stream index j+12k lines B's phase up with A's at j=1
  task automatic t_tone_phase();
    reg_wr(8'h20, 16'h0000);
    get_pair();
    reg_wr(8'h20, 16'h0003);
    for (int j = 0; j < 50; j++) begin
      get_pair();
      aref[j] = s_a;
      chk_s(s_b, s_a);
    end
    chk_s(aref[49], aref[1]);
    chk_b(aref[1] !== aref[25], 1'b1);
    chk_b(aref[1] !== 24'h000000, 1'b1);
    for (int k = 1; k < 4; k++) begin
      reg_wr(8'h20, 16'h0000);
      get_pair();
      reg_wr(8'h20, {6'h00, 2'(k), 8'h03});
      get_pair();
      get_pair();
      chk_s(s_b, aref[1 + 12 * k]);
    end
  endtask

  task automatic t_fifo_fill();
    logic [15:0] c0;
    int n;
    c0 = s_cnt;
    stall = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_sample_tick = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    i_sample_tick = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk_w(16'(level), 16'h0008);
    stall = 1'b0;
    n = 0;
    while (s_cnt != c0 + 16'h000a && n < 100) begin
      @(negedge i_ref_clk);
      n++;
    end
    repeat (5) @(negedge i_ref_clk);
    chk_w(s_cnt - c0, 16'h000a);
    chk_w(16'(level), 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad("watchdog timeout");
    stop_test();
  end

  initial begin
    repeat (5) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    @(negedge i_ref_clk);
    t_reset_regs();
    t_dc_level();
    t_tone_phase();
    t_fifo_fill();
    stop_test();
  end
endmodule
`default_nettype wire
